// [include/eipc_pkg.sv]
// eipc_pkg: shared constants for the external request priority controller
// assumes a 10 MHz ref_clk and a 32-bit APB register port
package eipc_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS   = 4;
  localparam int unsigned LVL_W      = 4;
  localparam int unsigned VEC_W      = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned STS_W      = 5;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CSR    = 8'h00; // irq_control_status
  localparam logic [7:0] ADDR_MODE   = 8'h04; // pin usage and vector source
  localparam logic [7:0] ADDR_PRIO   = 8'h08; // per-pin level, 4 bits each
  localparam logic [7:0] ADDR_ISTS   = 8'h0c; // sticky event status, read only
  localparam logic [7:0] ADDR_ICLR   = 8'h10; // write one to clear, write only
  localparam logic [7:0] ADDR_IEN    = 8'h14; // event enable
  localparam logic [7:0] ADDR_ACCEPT = 8'h18; // last offered level and last accepted vector

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CSR_SENSE_LSB = 8;  // two bits per pin, pin n at 2n+9:2n+8
  localparam int unsigned CSR_PIN_LSB   = 4;
  localparam int unsigned CSR_FLAG_LSB  = 0;
  localparam int unsigned MODE_VEC_BIT  = 0;  // vector_source_mode_bit
  localparam int unsigned MODE_USE_BIT  = 1;  // pin_usage_mode_bit
  localparam int unsigned ISTS_ACC_BIT  = 4;  // bits 3:0 edge seen per pin
  localparam int unsigned ACC_LVL_LSB   = 8;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  SENSE_RST  = 8'h00; // low-level detection on all pins
  localparam logic [1:0]  SENSE_LOW  = 2'h0;
  localparam logic [1:0]  SENSE_RISE = 2'h1;
  localparam logic [1:0]  SENSE_FALL = 2'h2;
  localparam logic [1:0]  SENSE_BOTH = 2'h3;
  localparam logic [1:0]  MODE_RST   = 2'h0;  // encoded-level use, auto vector
  localparam logic [15:0] PRIO_RST   = 16'h0000;
  localparam logic [7:0]  AUTO_VEC_BASE = 8'h40; // level 1 gives 64, 14 and 15 give 71
  localparam logic [7:0]  EXT_VEC_MASK  = 8'h7f; // external vector numbers 0..127

  // ----------------------------------------------------------------
  // compare stage timing: half core, one bus, one and a half peripheral
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CORE_CYC_NS   = 100;
  localparam int unsigned EBUS_CYC_NS   = 100;
  localparam int unsigned PERI_CYC_NS   = 100;
  localparam int unsigned CMP_TIME_NS   =
    (CORE_CYC_NS / 2) + EBUS_CYC_NS + ((3 * PERI_CYC_NS) / 2);
  localparam int unsigned CMP_CYC_RAW   =
    (CMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CMP_CYC       = (CMP_CYC_RAW < 1) ? 1 : CMP_CYC_RAW;
  localparam int unsigned CNT_W         = 4;

  // ----------------------------------------------------------------
  // compare stage states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMP  = 3'b010,
    ST_REQ  = 3'b100
  } eipc_state_t;
endpackage : eipc_pkg

// [core/eipc_ctrl.sv]
// eipc_ctrl: four request pins, detection, arbitration and core hand-off
// assumes an APB master on ref_clk and a processor core that pulses cpuAck
//
// Function
// RULE1 - two-bit sense per pin: low level, rising, falling, both; reset low level
// RULE2 - four read-only pin level bits, one for high; writes ignored
// RULE3 - in level mode a flag reads one while its pin is low
// RULE4 - in edge mode the selected edge sets the pin flag
// RULE5 - edge flag clears only by writing zero after reading it as one
// RULE6 - edge flag also clears when its interrupt is accepted
// RULE7 - highest programmed level among pending requests wins; others stay pending
// RULE8 - equal levels resolved by fixed default order
// RULE9 - winner held if level not above cpu mask, else signalled to core
// RULE10 - core checks request at next decode and enters exception handling
// RULE11 - core pushes status register and program counter on entry
// RULE12 - core copies accepted level into its mask field
// RULE13 - external vector mode takes vector from eight data inputs at fetch
// RULE14 - core jumps to vector table handler without delay slot
// RULE15 - compare stage takes half core, one bus, one and half peripheral cycles
// RULE16 - mode bit picks separate pins or encoded levels 1..15; encoded at reset
// RULE17 - vector mode bit picks internal or external vector, external 0..127
// RULE18 - pins synchronised before level or edge detection
`timescale 1ns/1ps
module eipc_ctrl
#(
  parameter int unsigned CMP_CYCLES = eipc_pkg::CMP_CYC
)
(
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           resetn,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [eipc_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [eipc_pkg::DATA_W-1:0]    pwdata,
  output logic      [eipc_pkg::DATA_W-1:0]    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // request pins, active low
  input  wire logic [eipc_pkg::NUM_PINS-1:0]  requestPinsN,
  // processor core side
  input  wire logic [eipc_pkg::LVL_W-1:0]     cpuMaskLevel,
  input  wire logic                           cpuAck,
  input  wire logic [eipc_pkg::VEC_W-1:0]     extData,
  output logic                                cpuIrq,
  output logic      [eipc_pkg::LVL_W-1:0]     cpuIrqLevel,
  output logic      [eipc_pkg::VEC_W-1:0]     acceptVector,
  // event interrupt
  output logic                                ctrlIrq
);
  import eipc_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_ff;
  logic       rstN;
  // release through two flops so every register leaves reset on one edge
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rstSync_ff <= 2'h0;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstN = rstSync_ff[1];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pinS1_ff;
  logic [NUM_PINS-1:0] pinS2_ff;
  logic [NUM_PINS-1:0] pinS3_ff;
  logic [NUM_PINS-1:0] pinState_ff;   // one = pin high
  logic [NUM_PINS-1:0] pinPrev_ff;
  // three stages; a level counts only once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      {pinS3_ff, pinS2_ff, pinS1_ff} <= '1;
    else
      {pinS3_ff, pinS2_ff, pinS1_ff} <= {pinS2_ff, pinS1_ff, requestPinsN}; // RULE18
  end
  // filtered level and its previous value feed the edge detector
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      {pinState_ff, pinPrev_ff} <= '1;
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
        if (pinS2_ff[i] == pinS3_ff[i])
          pinState_ff[i] <= pinS3_ff[i]; // RULE18
      pinPrev_ff <= pinState_ff;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apbAccess;
  logic apbWr;
  logic apbRd;
  logic hitCsr;
  logic hitMode;
  logic hitPrio;
  logic hitIclr;
  logic hitIen;
  logic mapped;
  // zero wait states, so every access completes in its first access cycle
  assign apbAccess = psel & penable;
  assign apbWr     = apbAccess & pwrite;
  assign apbRd     = apbAccess & ~pwrite;
  assign hitCsr    = (paddr == ADDR_CSR);
  assign hitMode   = (paddr == ADDR_MODE);
  assign hitPrio   = (paddr == ADDR_PRIO);
  assign hitIclr   = (paddr == ADDR_ICLR);
  assign hitIen    = (paddr == ADDR_IEN);
  assign mapped    = hitCsr | hitMode | hitPrio | hitIclr | hitIen |
                     (paddr == ADDR_ISTS) | (paddr == ADDR_ACCEPT);
  assign pready    = 1'b1;
  assign pslverr   = apbAccess & ~mapped;

  // ----------------------------------------------------------------
  // software control registers
  // ----------------------------------------------------------------
  logic [7:0]       senseSel_ff;
  logic [1:0]       mode_ff;
  logic [15:0]      prio_ff;
  logic [STS_W-1:0] irqEn_ff;
  // sense, mode, priority and enable; pin level bits have no storage
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      senseSel_ff <= SENSE_RST; // RULE1
      mode_ff     <= MODE_RST;  // RULE16
      prio_ff     <= PRIO_RST;
      irqEn_ff    <= '0;
    end
    else if (apbWr)
    begin
      if (hitCsr)
        senseSel_ff <= pwdata[CSR_SENSE_LSB +: 8]; // RULE1 RULE2
      if (hitMode)
        mode_ff <= pwdata[1:0]; // RULE16 RULE17
      if (hitPrio)
        prio_ff <= pwdata[15:0];
      if (hitIen)
        irqEn_ff <= pwdata[STS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] edgeHit;
  logic [NUM_PINS-1:0] levelMode;
  logic [NUM_PINS-1:0] edgeFlag_ff;
  logic [NUM_PINS-1:0] nxt_edgeFlag;
  logic [NUM_PINS-1:0] armed_ff;
  logic [NUM_PINS-1:0] flagView;
  logic [NUM_PINS-1:0] ackClear;
  logic                useIrq;
  assign useIrq = mode_ff[MODE_USE_BIT];
  // selected edges per pin from consecutive filtered samples
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      logic [1:0] s;
      logic       rise;
      logic       fall;
      s    = senseSel_ff[2*i +: 2];
      rise = pinState_ff[i] & ~pinPrev_ff[i];
      fall = ~pinState_ff[i] & pinPrev_ff[i];
      levelMode[i] = (s == SENSE_LOW);
      edgeHit[i]   = ((s == SENSE_RISE) & rise) | ((s == SENSE_FALL) & fall) |
                     ((s == SENSE_BOTH) & (rise | fall)); // RULE4 RULE1
      flagView[i]  = levelMode[i] ? ~pinState_ff[i] : edgeFlag_ff[i]; // RULE3
    end
  end
  // edge flags: a new edge beats any clear in the same cycle
  always_comb
  begin
    nxt_edgeFlag = edgeFlag_ff;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (apbWr & hitCsr & armed_ff[i] & ~pwdata[CSR_FLAG_LSB + i])
        nxt_edgeFlag[i] = 1'b0; // RULE5
      if (ackClear[i])
        nxt_edgeFlag[i] = 1'b0; // RULE6
      if (levelMode[i])
        nxt_edgeFlag[i] = 1'b0;
      if (edgeHit[i])
        nxt_edgeFlag[i] = 1'b1; // RULE4
    end
  end
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      edgeFlag_ff <= '0;
    else
      edgeFlag_ff <= nxt_edgeFlag;
  end
  // a read that sees a one arms that flag for the next zero write
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      armed_ff <= '0;
    else if (apbRd & hitCsr)
      armed_ff <= edgeFlag_ff & ~levelMode; // RULE5
    else if (apbWr & hitCsr)
      armed_ff <= '0; // RULE5
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [LVL_W-1:0]    winLevel;
  logic [1:0]          winPin;
  logic                winValid;
  // scan from the lowest default rank up, so ties keep the lower pin index
  always_comb
  begin
    winLevel = '0;
    winPin   = 2'h0;
    winValid = 1'b0;
    if (useIrq)
    begin
      for (int i = NUM_PINS - 1; i >= 0; i--)
        if (flagView[i] && (prio_ff[LVL_W*i +: LVL_W] >= winLevel) &&
            (prio_ff[LVL_W*i +: LVL_W] != '0))
        begin
          winLevel = prio_ff[LVL_W*i +: LVL_W]; // RULE7 RULE8
          winPin   = 2'(i);
          winValid = 1'b1;
        end
    end
    else
    begin
      winLevel = ~pinState_ff; // RULE16
      winValid = (winLevel != '0);
    end
  end

  // ----------------------------------------------------------------
  // compare stage and core hand-off
  // ----------------------------------------------------------------
  eipc_state_t       state_ff;
  eipc_state_t       nxt_state;
  logic [CNT_W-1:0]  cmpCnt_ff;
  logic [LVL_W-1:0]  heldLevel_ff;
  logic              aboveMask;
  logic              offerOk;
  logic              accept;
  assign aboveMask = winValid & (winLevel > cpuMaskLevel); // RULE9
  assign offerOk   = (state_ff == ST_REQ) & aboveMask & (winLevel == cpuIrqLevel); // RULE9
  assign accept    = offerOk & cpuAck;
  assign cpuIrq    = offerOk; // RULE9
  // the winning level must stay stable for the whole compare time; a new level recompares
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
        if (aboveMask)
          nxt_state = ST_CMP;
      ST_CMP:
        if (!aboveMask || (winLevel != heldLevel_ff))
          nxt_state = ST_IDLE;
        else if (cmpCnt_ff == CNT_W'(CMP_CYCLES - 1))
          nxt_state = ST_REQ; // RULE15
      ST_REQ:
        if (!offerOk || accept)
          nxt_state = ST_IDLE; // RULE9
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end
  // compare counter and the level under comparison
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cmpCnt_ff    <= '0;
      heldLevel_ff <= '0;
    end
    else if (state_ff == ST_CMP)
      cmpCnt_ff <= cmpCnt_ff + CNT_W'(1); // RULE15
    else
    begin
      cmpCnt_ff    <= CNT_W'(1);
      heldLevel_ff <= winLevel;
    end
  end
  // level latched on entry to the request; it stays as the last offered level
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      cpuIrqLevel <= '0;
    else if ((state_ff == ST_CMP) && (nxt_state == ST_REQ))
      cpuIrqLevel <= heldLevel_ff;
  end
  assign ackClear = (accept & useIrq & ~levelMode[winPin]) ?
                    (NUM_PINS'(1) << winPin) : '0; // RULE6
  // vector captured at the acceptance, which is the vector fetch cycle
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      acceptVector <= '0;
    else if (accept)
    begin
      if (mode_ff[MODE_VEC_BIT])
        acceptVector <= extData & EXT_VEC_MASK; // RULE13 RULE17
      else
        acceptVector <= AUTO_VEC_BASE + VEC_W'(winLevel >> 1); // RULE17
    end
  end

  // ----------------------------------------------------------------
  // event status and interrupt
  // ----------------------------------------------------------------
  logic [STS_W-1:0] irqSts_ff;
  logic [STS_W-1:0] stsSet;
  logic [STS_W-1:0] stsClr;
  assign stsSet = {accept, edgeHit};
  assign stsClr = (apbWr & hitIclr) ? pwdata[STS_W-1:0] : '0;
  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      irqSts_ff <= '0;
    else
      irqSts_ff <= (irqSts_ff & ~stsClr) | stsSet;
  end
  assign ctrlIrq = |(irqSts_ff & irqEn_ff);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb
  begin
    prdata = '0;
    if (apbRd)
    begin
      if (hitCsr)
        prdata[15:0] = {senseSel_ff, pinState_ff, flagView}; // RULE2 RULE3
      else if (hitMode)
        prdata[1:0] = mode_ff;
      else if (hitPrio)
        prdata[15:0] = prio_ff;
      else if (paddr == ADDR_ISTS)
        prdata[STS_W-1:0] = irqSts_ff;
      else if (hitIen)
        prdata[STS_W-1:0] = irqEn_ff;
      else if (paddr == ADDR_ACCEPT)
        prdata[15:0] = {4'h0, cpuIrqLevel, acceptVector};
    end
  end
endmodule : eipc_ctrl

// [sim/eipc_ctrl_props.sv]
// eipc_ctrl_props: port level assertions for eipc_ctrl
// assumes one ref_clk domain and the register map of eipc_pkg
`timescale 1ns/1ps
module eipc_ctrl_chk
#(
  parameter int unsigned CMP_CYCLES = 3
)
(
  // clock and reset
  input wire logic                         ref_clk,
  input wire logic                         resetn,
  // apb
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [eipc_pkg::ADDR_W-1:0]  paddr,
  input wire logic [eipc_pkg::DATA_W-1:0]  pwdata,
  input wire logic [eipc_pkg::DATA_W-1:0]  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  // pins and core
  input wire logic [eipc_pkg::NUM_PINS-1:0] requestPinsN,
  input wire logic [eipc_pkg::LVL_W-1:0]   cpuMaskLevel,
  input wire logic                         cpuAck,
  input wire logic [eipc_pkg::VEC_W-1:0]   extData,
  input wire logic                         cpuIrq,
  input wire logic [eipc_pkg::LVL_W-1:0]   cpuIrqLevel,
  input wire logic [eipc_pkg::VEC_W-1:0]   acceptVector,
  input wire logic                         ctrlIrq
);
  import eipc_pkg::*;
  logic       acc;
  logic       modeVec_ff;
  logic       modeUse_ff;
  logic [3:0] calm_ff;
  assign acc = psel && penable;
  // shadow of the mode register, taken at the apb access edge
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      {modeUse_ff, modeVec_ff} <= 2'b00;
    else if (acc && pwrite && paddr == ADDR_MODE)
      {modeUse_ff, modeVec_ff} <= {pwdata[MODE_USE_BIT], pwdata[MODE_VEC_BIT]};
  end
  // quiet cycles; any write restarts it since it may move the arbitration
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      calm_ff <= 4'h0;
    else if (!$stable(requestPinsN) || !$stable(cpuMaskLevel) || (acc && pwrite))
      calm_ff <= 4'h0;
    else if (calm_ff != 4'hf)
      calm_ff <= calm_ff + 4'h1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    cpuAck && cpuIrq;
  endsequence
  sequence s_rest;
    !cpuIrq [*2];
  endsequence
  chk_mask_cmp: assert property (cpuIrq |-> cpuIrqLevel > cpuMaskLevel)
    else $error("request offered at or below the mask");
  chk_ack_rest: assert property (s_take |=> s_rest)
    else $error("request offered again without a compare stage");
  chk_level_kept: assert property (s_take |=> cpuIrqLevel == $past(cpuIrqLevel))
    else $error("accepted level changed at accept");
  chk_vec_ext: assert property (s_take ##0 modeVec_ff |=>
    acceptVector == ($past(extData) & EXT_VEC_MASK))
    else $error("external vector not taken");
  chk_vec_auto: assert property (s_take ##0 !modeVec_ff |=>
    acceptVector == AUTO_VEC_BASE + ($past(cpuIrqLevel) >> 1))
    else $error("auto vector wrong");
  chk_pin_level: assert property ((acc && !pwrite && paddr == ADDR_CSR && calm_ff > 4'h5)
    |-> prdata[7:4] == requestPinsN)
    else $error("pin level bits wrong");
  chk_bad_addr: assert property (acc && paddr > ADDR_ACCEPT |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  chk_encoded: assert property ((!modeUse_ff && calm_ff == 4'hf && ~requestPinsN > cpuMaskLevel)
    |-> cpuIrq && cpuIrqLevel == ~requestPinsN)
    else $error("encoded level not offered");
endmodule : eipc_ctrl_chk

bind eipc_ctrl eipc_ctrl_chk #(.CMP_CYCLES(CMP_CYCLES)) u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .requestPinsN(requestPinsN), .cpuMaskLevel(cpuMaskLevel), .cpuAck(cpuAck),
  .extData(extData), .cpuIrq(cpuIrq), .cpuIrqLevel(cpuIrqLevel),
  .acceptVector(acceptVector), .ctrlIrq(ctrlIrq));

// [sim/eipc_core_model.sv]
// eipc_core_model: processor core facing eipc_ctrl
// assumes the controller takes cpuAck only while cpuIrq is high
`timescale 1ns/1ps
module eipc_core_model
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // controller side
  input  wire logic                       cpuIrq,
  input  wire logic [eipc_pkg::LVL_W-1:0] cpuIrqLevel,
  output logic      [eipc_pkg::LVL_W-1:0] cpuMaskLevel,
  output logic                            cpuAck,
  output logic      [eipc_pkg::VEC_W-1:0] extData,
  // bench control
  input  wire logic [3:0]                 ackDelay,
  input  wire logic                       maskLoad,
  input  wire logic [eipc_pkg::LVL_W-1:0] maskIn,
  input  wire logic [eipc_pkg::VEC_W-1:0] vecIn
);
  import eipc_pkg::*;
  logic [3:0] wait_ff;
  logic [3:0] mask_ff;
  logic [3:0] savedMask_ff;
  logic [7:0] depth_ff;
  logic       ack_ff;
  assign cpuAck       = ack_ff;
  assign cpuMaskLevel = mask_ff;
  // vector valid only in the fetch cycle; flipped otherwise so stale data shows
  assign extData      = ack_ff ? vecIn : ~vecIn;
  // decode check, exception entry and mask update; ackDelay models slow decode
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      {wait_ff, mask_ff, savedMask_ff, depth_ff, ack_ff} <= '0;
    else
    begin
      ack_ff <= 1'b0;
      if (ack_ff && cpuIrq)
      begin
        savedMask_ff <= mask_ff;
        depth_ff     <= depth_ff + 8'h02;
        mask_ff      <= cpuIrqLevel;
      end
      else if (maskLoad)
        mask_ff <= maskIn;
      if (!cpuIrq || ack_ff)
        wait_ff <= 4'h0;
      else if (wait_ff >= ackDelay)
        ack_ff <= 1'b1;
      else
        wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule : eipc_core_model

// [sim/testbench.sv]
// testbench: self-checking bench for eipc_ctrl
// assumes eipc_core_model on the core side and an apb master here
`timescale 1ns/1ps
module testbench;
  import eipc_pkg::*;
  logic        ref_clk, resetn, psel, penable, pwrite, maskLoad;
  logic        pready, pslverr, cpuAck, cpuIrq, ctrlIrq;
  logic [7:0]  paddr, vecIn, acceptVector, extData;
  logic [31:0] pwdata, prdata;
  logic [3:0]  requestPinsN, cpuMaskLevel, cpuIrqLevel, maskIn, ackDelay;
  int          fails, comparisons;
  eipc_ctrl DUT (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .requestPinsN(requestPinsN), .cpuMaskLevel(cpuMaskLevel),
    .cpuAck(cpuAck), .extData(extData), .cpuIrq(cpuIrq), .cpuIrqLevel(cpuIrqLevel),
    .acceptVector(acceptVector), .ctrlIrq(ctrlIrq));
  eipc_core_model u_core (.ref_clk(ref_clk), .resetn(resetn), .cpuIrq(cpuIrq),
    .cpuIrqLevel(cpuIrqLevel), .cpuMaskLevel(cpuMaskLevel), .cpuAck(cpuAck),
    .extData(extData), .ackDelay(ackDelay), .maskLoad(maskLoad), .maskIn(maskIn),
    .vecIn(vecIn));
  // 10 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic hang;
    fails++;
    complete_run();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      hang();
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rdc
  task automatic pins(input logic [3:0] v);
    @(posedge ref_clk);
    requestPinsN <= v;
  endtask : pins
  task automatic setmask(input logic [3:0] m);
    @(posedge ref_clk);
    {maskIn, maskLoad} <= {m, 1'b1};
    @(posedge ref_clk);
    maskLoad <= 1'b0;
  endtask : setmask
  task automatic irqis(input logic exp);
    @(negedge ref_clk);
    chk(ctrlIrq, exp);
  endtask : irqis
  // count offered requests over n cycles
  task automatic quiet(input int n);
    int seen;
    seen = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      seen += (cpuIrq !== 1'b0);
    end
    chk(seen, 0);
  endtask : quiet
  // wait for an accept; outputs are settled at the negedge after it
  task automatic take;
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (!(cpuAck === 1'b1 && cpuIrq === 1'b1) && n < 60);
    if (n >= 60)
      hang();
    @(negedge ref_clk);
  endtask : take
  task automatic sc_regs;
    logic [31:0] r;
    logic        e;
    rdc(ADDR_CSR, 32'h00f0);
    rdc(ADDR_MODE, 32'h0);
    wr(ADDR_CSR, 32'h000f);
    rdc(ADDR_CSR, 32'h00f0);
    wr(ADDR_ISTS, 32'h1f);
    rdc(ADDR_ISTS, 32'h0);
    apb(1'b1, 8'h1c, 32'h1, r, e);
    chk(e, 1'b1);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask : sc_regs
  task automatic sc_level;
    wr(ADDR_MODE, 32'h2);
    wr(ADDR_PRIO, 32'h5);
    setmask(4'h5);
    pins(4'he);
    quiet(12);
    rdc(ADDR_CSR, 32'h00e1);
    setmask(4'h4);
    take();
    chk({cpuMaskLevel, cpuIrqLevel, acceptVector}, 32'h5542);
    pins(4'hf);
    repeat (8) @(posedge ref_clk);
    rdc(ADDR_CSR, 32'h00f0);
    rdc(ADDR_ACCEPT, 32'h0542);
  endtask : sc_level
  task automatic sc_edge;
    logic [31:0] s;
    wr(ADDR_PRIO, 32'h0);
    wr(ADDR_IEN, 32'h2);
    for (int m = 1; m < 4; m++)
    begin
      s = 32'(m) << 10;
      wr(ADDR_CSR, s);
      pins(4'hd);
      repeat (8) @(posedge ref_clk);
      rdc(ADDR_CSR, s | 32'hd0 | 32'(m[1]) << 1);
      wr(ADDR_CSR, s);
      rdc(ADDR_CSR, s | 32'hd0);
      pins(4'hf);
      repeat (8) @(posedge ref_clk);
      wr(ADDR_CSR, s);
      rdc(ADDR_CSR, s | 32'hf0 | 32'(m[0]) << 1);
      wr(ADDR_CSR, s);
      rdc(ADDR_CSR, s | 32'hf0);
    end
    irqis(1'b1);
    wr(ADDR_IEN, 32'h0);
    irqis(1'b0);
    wr(ADDR_IEN, 32'h2);
    rdc(ADDR_ISTS, 32'h12);
    wr(ADDR_ICLR, 32'h1f);
    irqis(1'b0);
  endtask : sc_edge
  task automatic sc_prio;
    @(posedge ref_clk);
    ackDelay <= 4'h5;
    wr(ADDR_CSR, 32'haa00);
    wr(ADDR_PRIO, 32'h2773);
    setmask(4'h0);
    pins(4'h0);
    take();
    chk({cpuIrqLevel, acceptVector}, 32'h743);
    quiet(10);
    rdc(ADDR_CSR, 32'haa0d);
    setmask(4'h3);
    take();
    rdc(ADDR_CSR, 32'haa09);
    pins(4'hf);
    repeat (8) @(posedge ref_clk);
    rdc(ADDR_CSR, 32'haaf9);
    wr(ADDR_CSR, 32'haa00);
    rdc(ADDR_CSR, 32'haaf0);
  endtask : sc_prio
  task automatic sc_encoded;
    @(posedge ref_clk);
    {ackDelay, vecIn} <= {4'hf, 8'hc5};
    wr(ADDR_CSR, 32'h0);
    wr(ADDR_MODE, 32'h1);
    setmask(4'h0);
    pins(4'h6);
    take();
    chk({cpuMaskLevel, cpuIrqLevel, acceptVector}, 32'h9945);
    pins(4'h0);
    take();
    chk({cpuIrqLevel, acceptVector}, 32'hf45);
    pins(4'hf);
    wr(ADDR_MODE, 32'h0);
    setmask(4'h0);
    pins(4'he);
    take();
    chk(acceptVector, 32'h40);
    pins(4'h1);
    take();
    chk(acceptVector, 32'h47);
    pins(4'hf);
  endtask : sc_encoded
  // reset held three cycles, then each scenario in turn
  initial
  begin
    {fails, comparisons} = '0;
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {maskLoad, maskIn, ackDelay, vecIn} = '0;
    requestPinsN = 4'hf;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sc_regs();
    sc_level();
    sc_edge();
    sc_prio();
    sc_encoded();
    complete_run();
  end
endmodule : testbench
